// File: hw/smb_pkg.sv
// Shared constants and types for the mode register and burst ordering block.
package smb_pkg;

   localparam int SMB_ROW_W  = 14;
   localparam int SMB_COL_W  = 10;
   localparam int SMB_BA_W   = 2;
   localparam int SMB_DQ_W   = 8;
   localparam int SMB_WORD_W = 16;
   localparam int SMB_IDX_W  = 6;
   localparam int SMB_DEPTH  = 64;

   // Positions of the pins inside the synchroniser vector.
   localparam int SMB_PIN_W      = 30;
   localparam int SMB_PIN_CK     = 29;
   localparam int SMB_PIN_CKE    = 28;
   localparam int SMB_PIN_CS_N   = 27;
   localparam int SMB_PIN_CMD    = 24;
   localparam int SMB_PIN_BA     = 22;
   localparam int SMB_PIN_A      = 8;
   localparam int SMB_PIN_DQ     = 0;

   // Command codes as {ras_n, cas_n, we_n}.
   localparam logic [2:0] SMB_CMD_MRS = 3'h0;
   localparam logic [2:0] SMB_CMD_PRE = 3'h2;
   localparam logic [2:0] SMB_CMD_ACT = 3'h3;
   localparam logic [2:0] SMB_CMD_WR  = 3'h4;
   localparam logic [2:0] SMB_CMD_RD  = 3'h5;
   localparam int         SMB_A_ALL_BANKS = 10;

   localparam logic [1:0] SMB_BA_STD = 2'h0;
   localparam logic [1:0] SMB_BA_EXT = 2'h2;

   // Standard mode register fields.
   localparam int SMB_MR_BL    = 0;
   localparam int SMB_MR_ORDER = 3;
   localparam int SMB_MR_CL    = 4;
   localparam logic [2:0] SMB_BL_CODE_2  = 3'h1;
   localparam logic [2:0] SMB_BL_CODE_4  = 3'h2;
   localparam logic [2:0] SMB_BL_CODE_8  = 3'h3;
   localparam logic [2:0] SMB_BL_CODE_16 = 3'h4;
   localparam logic [2:0] SMB_CL_CODE_2  = 3'h2;
   localparam logic [2:0] SMB_CL_CODE_3  = 3'h3;

   // Extended register fields.
   localparam int SMB_EMR_DS = 5;
   localparam int SMB_EMR_RC = 0;
   localparam logic [2:0] SMB_DS_FULL    = 3'h0;
   localparam logic [2:0] SMB_DS_RSV_MIN = 3'h5;
   localparam logic [2:0] SMB_RC_FOUR    = 3'h0;
   localparam logic [2:0] SMB_RC_TWO     = 3'h1;
   localparam logic [2:0] SMB_RC_ONE     = 3'h2;
   localparam logic [2:0] SMB_RC_EIGHTH  = 3'h5;
   localparam logic [2:0] SMB_RC_SIXTH   = 3'h6;

   // Reset values of the mode state.
   localparam logic [2:0] SMB_BL_RESET = 3'h1;
   localparam logic [2:0] SMB_CL_RESET = 3'h3;

   // APB register offsets and fields.
   localparam logic [7:0] SMB_REG_CTRL   = 8'h00;
   localparam logic [7:0] SMB_REG_STATUS = 8'h04;
   localparam logic [7:0] SMB_REG_MODE   = 8'h08;
   localparam logic [7:0] SMB_REG_BURST  = 8'h0c;
   localparam logic       SMB_CTRL_RESET = 1'b1;
   localparam int SMB_ST_ERR      = 2;
   localparam int SMB_MODE_DS     = 16;
   localparam int SMB_MODE_RC     = 20;
   localparam int SMB_BURST_BANK  = 12;
   localparam int SMB_BURST_ROW   = 16;

   typedef enum logic [1:0] {
      SMB_IDLE    = 2'b00,
      SMB_RD_WAIT = 2'b01,
      SMB_RD      = 2'b10,
      SMB_WR      = 2'b11
   } smb_burst_t;

endpackage

// File: hw/smb_col_store.sv
// Column store: byte-wide cells, two written and two read per access.
`timescale 1ns/1ps
`default_nettype none
module smb_col_store
   import smb_pkg::*;
(
   input  wire logic                  clk_i,
   input  wire logic                  we_i,
   input  wire logic [SMB_IDX_W-1:0]  waddr_a_i,
   input  wire logic [SMB_IDX_W-1:0]  waddr_b_i,
   input  wire logic [SMB_WORD_W-1:0] wdata_i,
   input  wire logic [SMB_IDX_W-1:0]  raddr_a_i,
   input  wire logic [SMB_IDX_W-1:0]  raddr_b_i,
   output logic      [SMB_WORD_W-1:0] rdata_o
);

   logic [SMB_DQ_W-1:0] mem [SMB_DEPTH];

   always_ff @(posedge clk_i)
   begin
      if (we_i)
      begin
         mem[waddr_a_i] <= wdata_i[SMB_DQ_W-1:0];
         mem[waddr_b_i] <= wdata_i[SMB_WORD_W-1:SMB_DQ_W];
      end
      rdata_o <= {mem[raddr_b_i], mem[raddr_a_i]};
   end

endmodule
`default_nettype wire

// File: hw/smb_mode_burst.sv
// Mode registers, bank and row capture, and burst column ordering engine.
//
// How it works
// - Order bit of the standard register picks sequential or interleaved.
// - Lengths two, four, eight keep block bits; low bits give start.
// - Sequential counts up from start and wraps inside the block.
// - Interleaved XORs the start low bits with a rising count.
// - Drive field codes 000 to 100 pick strength; others reserved.
// - Refresh coverage field limits self refresh; other codes reserved.
// - Load with BA1 high and BA0 low writes the extended register.
// - ACTIVE opens a bank row; READ or WRITE follows it.
// - Address captured with READ or WRITE is the burst start column.
// - One double word per clock, sent as two half-cycle transfers.
// - Standard and extended loads are accepted in either order.
// - Standard load: bits 0-2 length, 3 order, 4-6 latency.
// - Standard register is loaded only with both bank bits low.
// - Mode contents hold until reloaded or power is lost.
// - Latency field gives two or three clocks to first read data; the code gives one clock for code 2 and two for any other code.
// - Length sixteen keeps bits 4-9 and starts at the low four.
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module smb_mode_burst (
   input  wire logic                       MCLK_I,
   input  wire logic                       RESET_I,
   input  wire logic                       PSEL_I,
   input  wire logic                       PENABLE_I,
   input  wire logic                       PWRITE_I,
   input  wire logic [7:0]                 PADDR_I,
   input  wire logic [31:0]                PWDATA_I,
   output logic      [31:0]                PRDATA_O,
   output logic                            PREADY_O,
   output logic                            PSLVERR_O,
   input  wire logic                       CK_I,
   input  wire logic                       CKE_I,
   input  wire logic                       CS_N_I,
   input  wire logic                       RAS_N_I,
   input  wire logic                       CAS_N_I,
   input  wire logic                       WE_N_I,
   input  wire logic [smb_pkg::SMB_BA_W-1:0]  BA_I,
   input  wire logic [smb_pkg::SMB_ROW_W-1:0] ADDR_I,
   input  wire logic [smb_pkg::SMB_DQ_W-1:0]  DQ_I,
   output logic      [smb_pkg::SMB_DQ_W-1:0]  DQ_O,
   output logic                            DQ_OE_O,
   output logic                            DQS_O,
   output logic                            DQS_OE_O,
   output logic      [2:0]                 DRIVE_STRENGTH_O,
   output logic      [3:0]                 REFRESH_BANK_MASK_O,
   output logic      [1:0]                 REFRESH_ROW_SHIFT_O
);
   import smb_pkg::*;

   function automatic logic [3:0] smb_bl_mask(input logic [2:0] code);
      case (code)
         SMB_BL_CODE_4:  return 4'h3;
         SMB_BL_CODE_8:  return 4'h7;
         SMB_BL_CODE_16: return 4'hf;
         default:        return 4'h1;
      endcase
   endfunction

   // The mask keeps the block bits of the start and wraps the low ones.
   function automatic logic [3:0] smb_burst_col(input logic [3:0] start,
                                                input logic [3:0] k,
                                                input logic [3:0] mask,
                                                input logic       ilv);
      logic [3:0] low;
      low = ilv ? (start ^ k) : 4'(start + k);
      return (start & ~mask) | (low & mask);
   endfunction

   logic [SMB_PIN_W-1:0] pin_s1;
   logic [SMB_PIN_W-1:0] pin_s2;
   logic                 ck_prev;
   logic                 rise;
   logic                 fall;
   logic [2:0]           cmd;
   logic [1:0]           ba;
   logic [13:0]          addr;
   logic [7:0]           dq_in;
   logic                 cmd_go;
   logic                 ctrl_enable;
   logic [2:0]           bl_code;
   logic                 interleave;
   logic [2:0]           cl_code;
   logic [2:0]           ds_code;
   logic [2:0]           rc_code;
   logic                 std_loaded;
   logic                 ext_loaded;
   logic [3:0]           bank_open;
   logic [13:0]          open_row [4];
   logic                 err;
   logic                 bad_set;
   logic                 err_clr;
   smb_burst_t           state;
   logic [9:0]           start_col;
   logic [1:0]           bank;
   logic [4:0]           beat;
   logic [1:0]           lat_cnt;
   logic [7:0]           hi_byte;
   logic [7:0]           wr_lo;
   logic                 wr_have;
   logic [3:0]           mask;
   logic [4:0]           bl_len;
   logic [3:0]           col_a;
   logic [3:0]           col_b;
   logic [15:0]          mem_rdata;
   logic                 mem_we;
   logic                 rd_present;
   logic                 acc_go;
   logic                 apb_wr;

   // Pins cross into the MCLK domain through two flops.
   always_ff @(posedge MCLK_I)
   begin
      if (RESET_I)
      begin
         pin_s1  <= '0;
         pin_s2  <= '0;
         ck_prev <= 1'b0;
      end
      else
      begin
         pin_s1  <= {CK_I, CKE_I, CS_N_I, RAS_N_I, CAS_N_I, WE_N_I, BA_I,
                     ADDR_I, DQ_I};
         pin_s2  <= pin_s1;
         ck_prev <= pin_s2[SMB_PIN_CK];
      end
   end

   assign rise   = pin_s2[SMB_PIN_CK] & ~ck_prev;
   assign fall   = ~pin_s2[SMB_PIN_CK] & ck_prev;
   assign cmd    = pin_s2[SMB_PIN_CMD +: 3];
   assign ba     = pin_s2[SMB_PIN_BA +: SMB_BA_W];
   assign addr   = pin_s2[SMB_PIN_A +: SMB_ROW_W];
   assign dq_in  = pin_s2[SMB_PIN_DQ +: SMB_DQ_W];
   assign cmd_go = rise & pin_s2[SMB_PIN_CKE] & ~pin_s2[SMB_PIN_CS_N]
                   & ctrl_enable;
   assign acc_go = cmd_go & ((cmd == SMB_CMD_RD) | (cmd == SMB_CMD_WR));
   assign bad_set = acc_go & ~bank_open[ba];

   // Mode state changes only on a load; the reset stands for power loss.
   always_ff @(posedge MCLK_I)
   begin
      if (RESET_I)
      begin
         bl_code    <= SMB_BL_RESET;
         interleave <= 1'b0;
         cl_code    <= SMB_CL_RESET;
         ds_code    <= SMB_DS_FULL;
         rc_code    <= SMB_RC_FOUR;
         std_loaded <= 1'b0;
         ext_loaded <= 1'b0;
      end
      else if (cmd_go && cmd == SMB_CMD_MRS)
      begin
         if (ba == SMB_BA_STD)
         begin
            bl_code    <= addr[SMB_MR_BL +: 3];
            interleave <= addr[SMB_MR_ORDER];
            cl_code    <= addr[SMB_MR_CL +: 3];
            std_loaded <= 1'b1;
         end
         else if (ba == SMB_BA_EXT)
         begin
            ds_code    <= addr[SMB_EMR_DS +: 3];
            rc_code    <= addr[SMB_EMR_RC +: 3];
            ext_loaded <= 1'b1;
         end
      end
   end

   // Decoded strength and coverage; reserved codes fall back to full.
   always_ff @(posedge MCLK_I)
   begin
      if (RESET_I)
      begin
         DRIVE_STRENGTH_O    <= SMB_DS_FULL;
         REFRESH_BANK_MASK_O <= 4'hf;
         REFRESH_ROW_SHIFT_O <= 2'h0;
      end
      else
      begin
         DRIVE_STRENGTH_O <= (ds_code < SMB_DS_RSV_MIN) ? ds_code
                                                          : SMB_DS_FULL;
         case (rc_code)
            SMB_RC_TWO:
            begin
               REFRESH_BANK_MASK_O <= 4'h3;
               REFRESH_ROW_SHIFT_O <= 2'h0;
            end
            SMB_RC_ONE:
            begin
               REFRESH_BANK_MASK_O <= 4'h1;
               REFRESH_ROW_SHIFT_O <= 2'h0;
            end
            SMB_RC_EIGHTH:
            begin
               REFRESH_BANK_MASK_O <= 4'h1;
               REFRESH_ROW_SHIFT_O <= 2'h1;
            end
            SMB_RC_SIXTH:
            begin
               REFRESH_BANK_MASK_O <= 4'h1;
               REFRESH_ROW_SHIFT_O <= 2'h2;
            end
            default:
            begin
               REFRESH_BANK_MASK_O <= 4'hf;
               REFRESH_ROW_SHIFT_O <= 2'h0;
            end
         endcase
      end
   end

   // Open rows per bank; precharge with the all-banks bit closes every bank.
   always_ff @(posedge MCLK_I)
   begin
      if (RESET_I)
      begin
         bank_open <= 4'h0;
         for (int i = 0; i < 4; i++)
            open_row[i] <= '0;
      end
      else if (cmd_go && cmd == SMB_CMD_ACT)
      begin
         bank_open[ba] <= 1'b1;
         open_row[ba]  <= addr;
      end
      else if (cmd_go && cmd == SMB_CMD_PRE)
      begin
         if (addr[SMB_A_ALL_BANKS])
            bank_open <= 4'h0;
         else
            bank_open[ba] <= 1'b0;
      end
   end

   // An access to a closed bank is flagged; a new event beats the clear.
   always_ff @(posedge MCLK_I)
   begin
      if (RESET_I)
         err <= 1'b0;
      else
         err <= bad_set | (err & ~err_clr);
   end

   assign mask       = smb_bl_mask(bl_code);
   assign bl_len     = 5'({1'b0, mask} + 5'h1);
   assign col_a      = smb_burst_col(start_col[3:0], beat[3:0], mask,
                                     interleave);
   assign col_b      = smb_burst_col(start_col[3:0], 4'(beat[3:0] + 4'h1),
                                     mask, interleave);
   assign rd_present = rise & (((state == SMB_RD_WAIT) && lat_cnt == 2'h1)
                       | ((state == SMB_RD) && beat != bl_len));
   assign mem_we     = fall & (state == SMB_WR) & wr_have;

   // Burst engine; a new READ or WRITE to an open bank restarts it.
   always_ff @(posedge MCLK_I)
   begin
      if (RESET_I)
      begin
         state     <= SMB_IDLE;
         start_col <= '0;
         bank      <= '0;
         beat      <= '0;
         lat_cnt   <= '0;
         wr_have   <= 1'b0;
         wr_lo     <= '0;
      end
      else if (acc_go && bank_open[ba])
      begin
         start_col <= addr[SMB_COL_W-1:0];
         bank      <= ba;
         beat      <= '0;
         wr_have   <= 1'b0;
         lat_cnt   <= (cl_code == SMB_CL_CODE_2) ? 2'h1 : 2'h2;
         state     <= (cmd == SMB_CMD_RD) ? SMB_RD_WAIT : SMB_WR;
      end
      else
      begin
         case (state)
            SMB_RD_WAIT:
               if (rise)
               begin
                  if (lat_cnt == 2'h1)
                  begin
                     state <= SMB_RD;
                     beat  <= 5'(beat + 5'h2);
                  end
                  else
                     lat_cnt <= 2'(lat_cnt - 2'h1);
               end
            SMB_RD:
               if (rise)
               begin
                  if (beat == bl_len)
                     state <= SMB_IDLE;
                  else
                     beat <= 5'(beat + 5'h2);
               end
            SMB_WR:
               if (rise)
               begin
                  if (beat == bl_len)
                     state <= SMB_IDLE;
                  else
                  begin
                     wr_lo   <= dq_in;
                     wr_have <= 1'b1;
                  end
               end
               else if (mem_we)
               begin
                  beat    <= 5'(beat + 5'h2);
                  wr_have <= 1'b0;
               end
            default:
               state <= SMB_IDLE;
         endcase
      end
   end

   // Low column on the rising half, high column on the falling half.
   always_ff @(posedge MCLK_I)
   begin
      if (RESET_I)
      begin
         DQ_O     <= '0;
         DQ_OE_O  <= 1'b0;
         DQS_O    <= 1'b0;
         DQS_OE_O <= 1'b0;
         hi_byte  <= '0;
      end
      else if (rd_present)
      begin
         DQ_O     <= mem_rdata[SMB_DQ_W-1:0];
         hi_byte  <= mem_rdata[SMB_WORD_W-1:SMB_DQ_W];
         DQ_OE_O  <= 1'b1;
         DQS_O    <= 1'b1;
         DQS_OE_O <= 1'b1;
      end
      else if (rise || state != SMB_RD)
      begin
         DQ_OE_O  <= 1'b0;
         DQS_O    <= 1'b0;
         DQS_OE_O <= 1'b0;
      end
      else if (fall)
      begin
         DQ_O  <= hi_byte;
         DQS_O <= 1'b0;
      end
   end

   smb_col_store u_store (
      .clk_i     (MCLK_I),
      .we_i      (mem_we),
      .waddr_a_i ({bank, col_a}),
      .waddr_b_i ({bank, col_b}),
      .wdata_i   ({dq_in, wr_lo}),
      .raddr_a_i ({bank, col_a}),
      .raddr_b_i ({bank, col_b}),
      .rdata_o   (mem_rdata)
   );

   assign apb_wr  = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I;
   assign err_clr = apb_wr & (PADDR_I == SMB_REG_STATUS) & PWDATA_I[SMB_ST_ERR];

   always_ff @(posedge MCLK_I)
   begin
      if (RESET_I)
         ctrl_enable <= SMB_CTRL_RESET;
      else if (apb_wr && PADDR_I == SMB_REG_CTRL)
         ctrl_enable <= PWDATA_I[0];
   end

   // Read data are captured in the setup cycle; one access cycle follows.
   always_ff @(posedge MCLK_I)
   begin
      if (RESET_I)
      begin
         PREADY_O  <= 1'b0;
         PRDATA_O  <= '0;
         PSLVERR_O <= 1'b0;
      end
      else if (PSEL_I && !PENABLE_I)
      begin
         PREADY_O  <= 1'b1;
         PSLVERR_O <= 1'b0;
         PRDATA_O  <= '0;
         if (PADDR_I == SMB_REG_CTRL)
            PRDATA_O <= {31'h0, ctrl_enable};
         else if (PADDR_I == SMB_REG_STATUS)
            PRDATA_O <= {28'h0, (state != SMB_IDLE), err, ext_loaded,
                         std_loaded};
         else if (PADDR_I == SMB_REG_MODE)
            PRDATA_O <= {9'h0, rc_code, 1'b0, ds_code, 9'h0, cl_code,
                         interleave, bl_code};
         else if (PADDR_I == SMB_REG_BURST)
            PRDATA_O <= {2'h0, open_row[bank], 2'h0, bank, 2'h0, start_col};
         else
            PSLVERR_O <= 1'b1;
      end
      else
      begin
         PREADY_O  <= 1'b0;
         PSLVERR_O <= 1'b0;
         PRDATA_O  <= '0;
      end
   end

   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (RESET_I);

   a_std_load: assert property (cmd_go && cmd == SMB_CMD_MRS && ba == SMB_BA_STD
      |=> bl_code == $past(addr[2:0]) && cl_code == $past(addr[6:4]))
      else $error("standard load did not set length and latency");
   a_order_bit: assert property (cmd_go && cmd == SMB_CMD_MRS && ba == 2'h0
      |=> interleave == $past(addr[3]))
      else $error("order bit not taken");
   a_ext_load: assert property (cmd_go && cmd == SMB_CMD_MRS && ba == 2'h2
      |=> ds_code == $past(addr[7:5]) && $stable(bl_code))
      else $error("extended load wrong");
   a_mode_hold: assert property (!(cmd_go && cmd == SMB_CMD_MRS)
      |=> $stable(bl_code) && $stable(ds_code) && $stable(rc_code))
      else $error("mode changed without a load");
   a_block_kept: assert property (state != SMB_IDLE
      |-> (col_a & ~mask) == (start_col[3:0] & ~mask))
      else $error("burst left its block");
   a_pair_order: assert property (state == SMB_RD && beat != bl_len
      |-> ((col_b & mask) == (interleave ? ((col_a ^ 4'h1) & mask)
           : (4'(col_a + 4'h1) & mask))))
      else $error("column pair out of order");
   a_start_col: assert property (acc_go && bank_open[ba]
      |=> col_a == $past(addr[3:0]) && start_col == $past(addr[9:0]))
      else $error("burst does not start at given column");
   a_low_half: assert property (rd_present
      |=> DQ_OE_O && DQ_O == $past(mem_rdata[7:0]))
      else $error("low half not presented");
   a_closed_bank: assert property (bad_set |=> err)
      else $error("access to closed bank not flagged");
   a_latency_two: assert property (acc_go && bank_open[ba] && cmd == SMB_CMD_RD
      && cl_code == SMB_CL_CODE_2 |=> lat_cnt == 2'h1)
      else $error("latency count wrong");

endmodule
`default_nettype wire

// File: bench/smb_ctrl_model.sv
// Memory controller model: memory clock, command pins and write data.
`timescale 1ns/1ps
`default_nettype none
module smb_ctrl_model (
   input  wire logic   clk_i,
   output logic        ck_o,
   output logic        cke_o,
   output logic        cs_n_o,
   output logic [2:0]  cmd_o,
   output logic [1:0]  ba_o,
   output logic [13:0] addr_o,
   output logic [7:0]  dq_o
);
   initial
   begin
      ck_o = 1'b0;
      cke_o = 1'b1;
      cs_n_o = 1'b1;
      cmd_o = 3'h7;
      ba_o = 2'h0;
      addr_o = 14'h0;
      dq_o = 8'h0;
   end

   // Clock enable may be dropped so that the device ignores commands.
   task automatic hold_cke(input logic v);
      cke_o <= v;
   endtask

   // One clock period of eight MCLK per call; the clock then stands low.
   task automatic cyc(input logic n, input logic [2:0] c,
                      input logic [1:0] b, input logic [13:0] a,
                      input logic [7:0] d0, d1);
      cs_n_o <= n;
      cmd_o <= c;
      ba_o <= b;
      addr_o <= a;
      dq_o <= d0;
      repeat (2) @(posedge clk_i);
      ck_o <= 1'b1;
      repeat (2) @(posedge clk_i);
      dq_o <= d1;
      repeat (2) @(posedge clk_i);
      ck_o <= 1'b0;
      cs_n_o <= 1'b1;
      ba_o <= ~b;
      addr_o <= ~a;
      @(posedge clk_i);
      dq_o <= ~d1;
      @(posedge clk_i);
   endtask

   task automatic nop(input int k);
      repeat (k) cyc(1'b1, 3'h7, 2'h0, 14'h0, 8'h5a, 8'ha5);
   endtask

   task automatic init(input logic [13:0] mr, input logic [13:0] emr);
      nop(625);
      cyc(1'b0, 3'h2, 2'h0, 14'h0400, 8'h0, 8'h0);
      nop(2);
      repeat (2)
      begin
         cyc(1'b0, 3'h1, 2'h0, 14'h0, 8'h0, 8'h0);
         nop(4);
      end
      cyc(1'b0, 3'h0, 2'h2, emr, 8'h0, 8'h0);
      nop(2);
      cyc(1'b0, 3'h0, 2'h0, mr, 8'h0, 8'h0);
      nop(2);
   endtask
endmodule
`default_nettype wire

// File: bench/tb.sv
// Self-checking bench for the mode register and burst ordering block.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import smb_pkg::*;
   logic        mclk, rst, psel, pen, pwr, er, pready, pslverr;
   logic        ck, cke, cs_n, oe, dqs, dqs_oe, pdqs, poe;
   logic [7:0]  paddr, dqi, dqo;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0]  cmd, drv;
   logic [1:0]  ba, rsh;
   logic [13:0] addr;
   logic [3:0]  rmask;
   logic [7:0]  got[$];
   time         tfirst;
   int          error_cnt, compares;
   logic [2:0]  bls[6] = '{3'h1, 3'h2, 3'h3, 3'h3, 3'h4, 3'h2};
   logic        ils[6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
   logic [2:0]  cls[6] = '{3'h2, 3'h3, 3'h3, 3'h2, 3'h2, 3'h3};
   logic [3:0]  sts[6] = '{4'h1, 4'h1, 4'h5, 4'h5, 4'h9, 4'h3};

   initial
   begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   smb_ctrl_model mdl (.clk_i(mclk), .ck_o(ck), .cke_o(cke),
      .cs_n_o(cs_n), .cmd_o(cmd), .ba_o(ba), .addr_o(addr), .dq_o(dqi));

   smb_mode_burst dut (.MCLK_I(mclk), .RESET_I(rst), .PSEL_I(psel),
      .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
      .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(pslverr), .CK_I(ck), .CKE_I(cke), .CS_N_I(cs_n),
      .RAS_N_I(cmd[2]), .CAS_N_I(cmd[1]), .WE_N_I(cmd[0]), .BA_I(ba),
      .ADDR_I(addr), .DQ_I(dqi), .DQ_O(dqo), .DQ_OE_O(oe), .DQS_O(dqs),
      .DQS_OE_O(dqs_oe), .DRIVE_STRENGTH_O(drv),
      .REFRESH_BANK_MASK_O(rmask), .REFRESH_ROW_SHIFT_O(rsh));

   // Each strobe level change while driving marks one new data byte.
   always @(posedge mclk)
   begin
      if (oe === 1'b1 && (dqs !== pdqs || poe !== 1'b1))
      begin
         if (got.size() == 0)
            tfirst = $time;
         got.push_back(dqo);
      end
      if (oe === 1'b1)
         chk("strobe enable", 32'h1, 32'(dqs_oe));
      pdqs <= dqs;
      poe <= oe;
   end

   task automatic summarize;
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e, g);
      compares++;
      if (g !== e)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      pen <= 1'b1;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge mclk);
      if (n >= 20)
      begin
         error_cnt++;
         summarize;
      end
   endtask

   function automatic logic [3:0] col(input logic [3:0] s, input int k,
                                      input int bl, input logic il);
      logic [3:0] m;
      m = 4'(bl - 1);
      return (s & ~m) | ((il ? (s ^ 4'(k)) : (s + 4'(k))) & m);
   endfunction

   task automatic setmode(input logic [13:0] mr);
      mdl.cyc(1'b0, SMB_CMD_PRE, 2'h0, 14'h0400, 8'h0, 8'h0);
      mdl.nop(2);
      mdl.cyc(1'b0, SMB_CMD_MRS, SMB_BA_STD, mr, 8'h0, 8'h0);
      mdl.nop(2);
      mdl.cyc(1'b0, SMB_CMD_ACT, 2'h1, 14'h2abc, 8'h0, 8'h0);
      mdl.nop(1);
   endtask

   task automatic t_ext;
      logic [2:0] c;
      for (int i = 0; i < 8; i++)
      begin
         c = 3'(7 - i);
         mdl.cyc(1'b0, SMB_CMD_MRS, SMB_BA_EXT, {6'h0, 3'(i), 2'h0, c},
                 8'h0, 8'h0);
         mdl.nop(1);
         chk("drive", (i < 5) ? 32'(i) : 32'h0, 32'(drv));
         chk("mask", (c == 3'h1) ? 32'h3 : (c inside {3'h2, 3'h5, 3'h6})
             ? 32'h1 : 32'hf, 32'(rmask));
         chk("shift", (c == 3'h5) ? 32'h1 : (c == 3'h6) ? 32'h2 : 32'h0,
             32'(rsh));
      end
      mdl.cyc(1'b0, SMB_CMD_MRS, 2'h1, 14'h3fff, 8'h0, 8'h0);
      mdl.nop(1);
      apb(1'b0, SMB_REG_MODE, 32'h0);
      chk("std held", 32'h24, 32'(rd[6:0]));
      $display("test ext done");
   endtask

   task automatic rd_burst(input int i);
      int bl;
      time t0;
      bl = 2 << (bls[i] - 1);
      setmode({7'h0, cls[i], ils[i], bls[i]});
      apb(1'b0, SMB_REG_MODE, 32'h0);
      chk("mode", 32'({cls[i], ils[i], bls[i]}), 32'(rd[6:0]));
      got.delete();
      t0 = $time + 80;
      mdl.cyc(1'b0, SMB_CMD_RD, 2'h1, {4'h0, 6'h2a, sts[i]}, 8'h0, 8'h0);
      mdl.nop(bl / 2 + 3);
      chk("latency", (cls[i] == SMB_CL_CODE_2) ? 32'h1 : 32'h2,
          32'((tfirst - t0) / 320));
      chk("count", 32'(bl), 32'(got.size()));
      for (int k = 0; k < bl && k < got.size(); k++)
         chk("byte", 32'(8'h40 + col(sts[i], k, bl, ils[i])),
             32'(got[k]));
      apb(1'b0, SMB_REG_BURST, 32'h0);
      chk("burst", {2'h0, 14'h2abc, 4'h1, 2'h0, 6'h2a, sts[i]}, rd);
      $display("test read %0d done", i);
   endtask

   initial
   begin
      rst = 1'b1;
      psel = 1'b0;
      pen = 1'b0;
      pwr = 1'b0;
      paddr = 8'h0;
      pwdata = 32'h0;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      apb(1'b1, SMB_REG_MODE, 32'hffffffff);
      apb(1'b0, SMB_REG_MODE, 32'h0);
      chk("mode reset", 32'h31, rd);
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped", 32'h1, 32'(er));
      chk("mask reset", 32'hf, 32'(rmask));
      mdl.init(14'h0024, 14'h0000);
      apb(1'b0, SMB_REG_STATUS, 32'h0);
      chk("loaded", 32'h3, rd);
      t_ext;
      setmode(14'h0024);
      mdl.cyc(1'b0, SMB_CMD_WR, 2'h1, 14'h0, 8'h0, 8'h0);
      for (int i = 0; i < 8; i++)
         mdl.cyc(1'b1, 3'h7, 2'h0, 14'h0, 8'(8'h40 + 2 * i),
                 8'(8'h41 + 2 * i));
      mdl.nop(2);
      for (int i = 0; i < 6; i++)
         rd_burst(i);
      got.delete();
      mdl.cyc(1'b0, SMB_CMD_RD, 2'h2, 14'h0, 8'h0, 8'h0);
      mdl.nop(4);
      apb(1'b0, SMB_REG_STATUS, 32'h0);
      chk("closed bank", 32'h7, rd);
      chk("no data", 32'h0, 32'(got.size()));
      apb(1'b1, SMB_REG_STATUS, 32'h4);
      apb(1'b0, SMB_REG_STATUS, 32'h0);
      chk("error clear", 32'h3, rd);
      apb(1'b1, SMB_REG_CTRL, 32'h0);
      mdl.cyc(1'b0, SMB_CMD_MRS, SMB_BA_STD, 14'h0011, 8'h0, 8'h0);
      mdl.nop(1);
      apb(1'b0, SMB_REG_MODE, 32'h0);
      chk("mode held", 32'h32, 32'(rd[6:0]));
      apb(1'b1, SMB_REG_CTRL, 32'h1);
      mdl.hold_cke(1'b0);
      mdl.cyc(1'b0, SMB_CMD_MRS, SMB_BA_STD, 14'h0011, 8'h0, 8'h0);
      mdl.hold_cke(1'b1);
      mdl.nop(1);
      apb(1'b0, SMB_REG_MODE, 32'h0);
      chk("cke low held", 32'h32, 32'(rd[6:0]));
      mdl.cyc(1'b0, SMB_CMD_MRS, SMB_BA_STD, 14'h0011, 8'h0, 8'h0);
      mdl.nop(1);
      apb(1'b0, SMB_REG_MODE, 32'h0);
      chk("reloaded", 32'h11, 32'(rd[6:0]));
      $display("test error done");
      summarize;
   end
endmodule
`default_nettype wire
